// >>> logic/gpt16_timer.sv
// 16-bit timer/counter with prescaler, gate accumulation and RTC mode.
// Assumes APB master on clk_sys; pins arrive asynchronous to clk_sys.
// How it works
// R01: Timer mode counts instruction cycles to the period, then wraps to zero.
// R02: In Idle, counting halts when stop-in-idle is set, resumes afterwards.
// R03: Synchronous counter mode syncs the external clock, counts rising edges.
// R04: Asynchronous counter counts external rising edges; halts in Idle only if asked.
// R05: Gate accumulation counts instruction cycles only while the gate pin is high.
// R06: Prescaler input is instruction clock or external clock per source select.
// R07: Prescale field 5:4 divides by 1, 8, 64 or 256.
// R08: Prescaler clears on count write, timer-on clearing and reset.
// R09: With timer-on low the prescaler counter holds its value.
// R10: Control writes never touch the count; only count writes change it.
// R11: Sleep counting needs timer-on, external source and asynchronous select.
// R12: In Sleep the count still wraps and raises matches.
// R13: Period match sets the sticky flag; only software clears it.
// R14: Gate falling edge in accumulation mode sets its own sticky gate flag.
// R15: Asynchronous external source counts the 32 kHz oscillator edges when the low-power osc is enabled.
// R16: Software keeps the synchronize bit low for RTC operation.
// R17: Low-power oscillator enable stops normal modes, wakes on carry-out.
// R18: RTC keeps running through Sleep; Idle obeys stop-in-idle.
// R19: Flag sets on the increment that finds equality; that same increment loads zero.
`default_nettype none
module gpt16_timer
    import gpt16_pkg::*;
(
    input  wire logic        clk_sys,  // 250 MHz system clock
    input  wire logic        arst_n,   // Asynchronous reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB enable
    input  wire logic        pwrite,   // APB direction
    input  wire logic [11:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error
    input  wire gpt16_pins_t pins,     // External clock/gate and oscillator
    output logic             irq       // Level interrupt
);
    // Two-stage synchronisers for both pins
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 2'b00;
            s2 <= 2'b00;
            s3 <= 2'b00;
        end else begin
            s1 <= {pins.lp_osc, pins.ext_clk};
            s2 <= s1;
            s3 <= s2;
        end
    end
    wire ext_lvl  = s2[0];
    wire ext_rise = s2[0] & ~s3[0];
    wire osc_rise = s2[1] & ~s3[1];
    wire gate_fall = ~s2[0] & s3[0];

    // Registers
    logic [15:0] count_register;
    logic [15:0] period_register;
    logic [15:0] control_register;
    logic [1:0]  oscillator_control_register;
    logic [1:0]  power_state;
    logic [GPT_NEV-1:0] status;
    logic [GPT_NEV-1:0] match_interrupt_enable;
    logic [7:0]  ps_cnt;
    logic [1:0]  icyc_div;

    // Field decode
    wire timer_on_bit          = control_register[GPT_B_ON];
    wire stop_in_idle_bit      = control_register[GPT_B_SIDL];
    wire gate_accum_enable     = control_register[GPT_B_GATE];
    wire clock_source_select   = control_register[GPT_B_CS];
    wire ext_clock_sync_select = control_register[GPT_B_SYNC];
    wire [1:0] prescale_select = control_register[GPT_B_PS_HI:GPT_B_PS_LO];
    wire lowpower_osc_enable   = oscillator_control_register[GPT_B_LPOSC];
    wire in_idle  = power_state[GPT_B_IDLE];
    wire in_sleep = power_state[GPT_B_SLEEP];

    // APB decode; single-cycle access phase
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    wire hit_count  = paddr == GPT_OFF_COUNT;
    wire hit_period = paddr == GPT_OFF_PERIOD;
    wire hit_ctrl   = paddr == GPT_OFF_CTRL;
    wire hit_osc    = paddr == GPT_OFF_OSC;
    wire hit_stat   = paddr == GPT_OFF_STAT;
    wire hit_clr    = paddr == GPT_OFF_CLR;
    wire hit_ien    = paddr == GPT_OFF_IEN;
    wire hit_pwr    = paddr == GPT_OFF_PWR;
    wire mapped = hit_count | hit_period | hit_ctrl | hit_osc | hit_stat
                | hit_clr | hit_ien | hit_pwr;
    wire wr_count = wr & hit_count;
    wire wr_ctrl  = wr & hit_ctrl;
    wire on_fall  = wr_ctrl & timer_on_bit & ~pwdata[GPT_B_ON];

    // Source selection; oscillator edges on the asynchronous path keep RTC alive
    gpt16_src_t src;
    assign src = !clock_source_select ? GPT_SRC_ICYC :
                 ext_clock_sync_select ? GPT_SRC_SYNC : GPT_SRC_ASYN;
    wire icyc_tick = icyc_div == GPT_ICYC_LAST;
    // External source: oscillator edges when the low-power osc runs
    wire ext_edge = lowpower_osc_enable ? osc_rise : ext_rise; // R15
    logic src_tick;
    always_comb begin
        case (src)
            GPT_SRC_ICYC: src_tick = icyc_tick & (~gate_accum_enable | ext_lvl); // R01 R05 R06
            GPT_SRC_SYNC: src_tick = ext_rise & ~lowpower_osc_enable;          // R03 R17
            GPT_SRC_ASYN: src_tick = ext_edge;                                  // R04 R15
            default:      src_tick = 1'b0;
        endcase
    end

    // Power-state gating
    wire sleep_ok = timer_on_bit & clock_source_select & ~ext_clock_sync_select; // R11
    wire run = timer_on_bit
             & ~(in_idle & stop_in_idle_bit)                 // R02 R18
             & (~in_sleep | sleep_ok);                        // R11 R18
    // Normal timer modes are disabled while the low-power osc is enabled
    wire mode_ok = ~lowpower_osc_enable | (src == GPT_SRC_ASYN); // R17

    // Prescaler terminal
    logic [7:0] ps_last;
    always_comb begin
        case (prescale_select)
            2'b00:   ps_last = GPT_PS_DIV1;   // R07
            2'b01:   ps_last = GPT_PS_DIV8;   // R07
            2'b10:   ps_last = GPT_PS_DIV64;  // R07
            2'b11:   ps_last = GPT_PS_DIV256; // R07
            default: ps_last = GPT_PS_DIV1;
        endcase
    end
    wire pre_in  = run & mode_ok & src_tick;
    wire inc     = pre_in & (ps_cnt >= ps_last);
    wire at_per  = count_register == period_register;
    wire ev_match = inc & at_per;                                  // R19
    wire ev_gate = timer_on_bit & gate_accum_enable & ~clock_source_select & gate_fall; // R14
    wire ev_wake = inc & lowpower_osc_enable & (count_register == 16'hFFFF);     // R17
    wire [GPT_NEV-1:0] ev_set;
    assign ev_set[GPT_EV_MATCH] = ev_match;
    assign ev_set[GPT_EV_GATE]  = ev_gate;
    assign ev_set[GPT_EV_WAKE]  = ev_wake;
    wire [GPT_NEV-1:0] clr_mask = (wr & hit_clr) ? pwdata[GPT_NEV-1:0] : '0;
    // Next status and enable; irq uses both so it never lags a clear or enable write
    wire [GPT_NEV-1:0] next_status    = ev_set | (status & ~clr_mask);
    wire [GPT_NEV-1:0] next_ien       =
        (wr & hit_ien) ? pwdata[GPT_NEV-1:0] : match_interrupt_enable;
    wire [GPT_NEV-1:0] next_status_en = next_status & next_ien;

    // Instruction-cycle divider, free running
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) icyc_div <= 2'b00;
        else         icyc_div <= icyc_div + 2'b01;
    end

    // Prescaler counter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ps_cnt <= 8'h00;                                 // R08
        end else if (wr_count || on_fall) begin
            ps_cnt <= 8'h00;                                 // R08
        end else if (pre_in) begin
            ps_cnt <= inc ? 8'h00 : ps_cnt + 8'h01;          // R09
        end
    end

    // Count register: only count writes or increments change it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_register <= GPT_RST_COUNT;
        end else if (wr_count) begin
            count_register <= pwdata[15:0];                  // R10
        end else if (inc) begin
            count_register <= at_per ? 16'h0000 : count_register + 16'h0001; // R01 R12 R19
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            period_register             <= GPT_RST_PERIOD;
            control_register            <= GPT_RST_CTRL;
            oscillator_control_register <= 2'b00;
            power_state                 <= 2'b00;
            match_interrupt_enable      <= '0;
        end else if (wr) begin
            if (hit_period) period_register <= pwdata[15:0];
            if (hit_ctrl)   control_register <= pwdata[15:0] & GPT_CTRL_MASK;
            if (hit_osc)    oscillator_control_register <= pwdata[1:0];
            if (hit_pwr)    power_state <= pwdata[1:0];
            if (hit_ien)    match_interrupt_enable <= pwdata[GPT_NEV-1:0];
        end
    end

    // Sticky status: hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) status <= '0;
        else         status <= next_status; // R13
    end

    // Read mux
    wire [31:0] rdata =
        hit_count  ? {16'h0000, count_register} :
        hit_period ? {16'h0000, period_register} :
        hit_ctrl   ? {16'h0000, control_register} :
        hit_osc    ? {30'h0, oscillator_control_register} :
        hit_stat   ? {29'h0, status} :
        hit_ien    ? {29'h0, match_interrupt_enable} :
        hit_pwr    ? {30'h0, power_state} : 32'h0000_0000;

    // Registered outputs; answer lands one cycle after setup
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata : 32'h0000_0000;
            irq     <= |(next_status_en);                    // R13 R12
        end
    end

    // Assertions
    property p_wrap;
        @(posedge clk_sys) disable iff (!arst_n)
        (inc && at_per && !wr_count) |=> count_register == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap at period"); // R01

    property p_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        ev_match |=> status[GPT_EV_MATCH];
    endproperty
    a_flag: assert property (p_flag) else $error("match flag not set"); // R13

    property p_sticky;
        @(posedge clk_sys) disable iff (!arst_n)
        (status[GPT_EV_MATCH] && !(wr && hit_clr && pwdata[GPT_EV_MATCH]))
            |=> status[GPT_EV_MATCH];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // R13

    property p_ctrl_keep;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_ctrl && !inc) |=> $stable(count_register);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved count"); // R10

    property p_ps_clr;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_count || on_fall) |=> ps_cnt == 8'h00;
    endproperty
    a_ps_clr: assert property (p_ps_clr) else $error("prescaler not cleared"); // R08

    property p_ps_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        !timer_on_bit |=> $stable(ps_cnt);
    endproperty
    a_ps_hold: assert property (p_ps_hold) else $error("prescaler moved while off"); // R09

    property p_idle;
        @(posedge clk_sys) disable iff (!arst_n)
        (in_idle && stop_in_idle_bit && !wr_count) |=> $stable(count_register);
    endproperty
    a_idle: assert property (p_idle) else $error("counted in idle"); // R02

    property p_sleep;
        @(posedge clk_sys) disable iff (!arst_n)
        (in_sleep && !sleep_ok && !wr_count) |=> $stable(count_register);
    endproperty
    a_sleep: assert property (p_sleep) else $error("counted in sleep"); // R11

    property p_gate;
        @(posedge clk_sys) disable iff (!arst_n)
        (!clock_source_select && gate_accum_enable && !ext_lvl) |-> !inc;
    endproperty
    a_gate: assert property (p_gate) else $error("counted with gate low"); // R05

    property p_div8;
        @(posedge clk_sys) disable iff (!arst_n)
        (inc && prescale_select == 2'b01) |-> $past(ps_cnt) <= 8'h07 && ps_cnt == 8'h07;
    endproperty
    a_div8: assert property (p_div8) else $error("divide-by-8 terminal wrong"); // R07

    // Interrupt line mirrors the enabled sticky bits
    property p_irq;
        @(posedge clk_sys) disable iff (!arst_n)
        irq == |(status & match_interrupt_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow flags"); // R13

    // A gate fall is never lost
    property p_gate_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        ev_gate |=> status[GPT_EV_GATE];
    endproperty
    a_gate_flag: assert property (p_gate_flag) else $error("gate flag not set"); // R14

    // Carry-out wake-up is latched like a match
    property p_wake_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        ev_wake |=> status[GPT_EV_WAKE];
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set"); // R17

    // Only the asynchronous path counts with the low-power osc on
    property p_lp_halt;
        @(posedge clk_sys) disable iff (!arst_n)
        (lowpower_osc_enable && src != GPT_SRC_ASYN) |-> !inc;
    endproperty
    a_lp_halt: assert property (p_lp_halt) else $error("normal mode counted"); // R17

    // Oscillator edges replace pin edges in the asynchronous path
    property p_osc_src;
        @(posedge clk_sys) disable iff (!arst_n)
        (src == GPT_SRC_ASYN && lowpower_osc_enable) |-> src_tick == osc_rise;
    endproperty
    a_osc_src: assert property (p_osc_src) else $error("osc edge not used"); // R15

    // Below the period every increment adds exactly one
    property p_step;
        @(posedge clk_sys) disable iff (!arst_n)
        (inc && !at_per && !wr_count) |=> count_register == $past(count_register) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step"); // R01

    // A count write lands as written
    property p_cnt_wr;
        @(posedge clk_sys) disable iff (!arst_n)
        wr_count |=> count_register == $past(pwdata[15:0]);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost"); // R10

    // A clear with no coinciding match drops the flag
    property p_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr && hit_clr && pwdata[GPT_EV_MATCH] && !ev_match) |=> !status[GPT_EV_MATCH];
    endproperty
    a_clear: assert property (p_clear) else $error("match flag not cleared"); // R13

    // Internal source, no gate: one prescaler step per instruction cycle
    property p_src_icyc;
        @(posedge clk_sys) disable iff (!arst_n)
        (timer_on_bit && !clock_source_select && !gate_accum_enable
            && !lowpower_osc_enable && !in_idle && !in_sleep) |-> pre_in == icyc_tick;
    endproperty
    a_src_icyc: assert property (p_src_icyc) else $error("internal tick not used"); // R06

    // Synchronous external source: one step per synchronised rising edge
    property p_src_ext;
        @(posedge clk_sys) disable iff (!arst_n)
        (timer_on_bit && clock_source_select && ext_clock_sync_select
            && !lowpower_osc_enable && !in_idle && !in_sleep) |-> pre_in == ext_rise;
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("external edge not used"); // R03 R06

    // Asynchronous counting survives Sleep, and survives Idle unless stop-in-idle is set
    property p_async_run;
        @(posedge clk_sys) disable iff (!arst_n)
        (src == GPT_SRC_ASYN && timer_on_bit && !stop_in_idle_bit && ext_edge) |-> pre_in;
    endproperty
    a_async_run: assert property (p_async_run) else $error("async edge dropped"); // R04 R18

    // Gate high and an instruction tick reach the prescaler when on, outside Idle and Sleep, with the low-power osc off
    property p_gate_run;
        @(posedge clk_sys) disable iff (!arst_n)
        (timer_on_bit && !clock_source_select && gate_accum_enable && ext_lvl
            && icyc_tick && !lowpower_osc_enable && !in_idle && !in_sleep) |-> pre_in;
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("gated tick dropped"); // R05

    // A match while sleeping still raises the flag
    property p_sleep_match;
        @(posedge clk_sys) disable iff (!arst_n)
        (in_sleep && inc && at_per) |=> status[GPT_EV_MATCH];
    endproperty
    a_sleep_match: assert property (p_sleep_match) else $error("no flag in sleep"); // R12
endmodule
`default_nettype wire

// >>> pkg/gpt16_pkg.sv
// Package for the 16-bit timer with real-time-clock mode.
// Assumes a single 250 MHz system clock and an APB register slave.
`default_nettype none
package gpt16_pkg;
    // Register byte offsets
    localparam logic [11:0] GPT_OFF_COUNT  = 12'h100;
    localparam logic [11:0] GPT_OFF_PERIOD = 12'h104;
    localparam logic [11:0] GPT_OFF_CTRL   = 12'h108;
    localparam logic [11:0] GPT_OFF_OSC    = 12'h10C;
    localparam logic [11:0] GPT_OFF_STAT   = 12'h110;
    localparam logic [11:0] GPT_OFF_CLR    = 12'h114;
    localparam logic [11:0] GPT_OFF_IEN    = 12'h118;
    localparam logic [11:0] GPT_OFF_PWR    = 12'h11C;
    // Control register fields
    localparam int GPT_B_ON    = 15;
    localparam int GPT_B_SIDL  = 13;
    localparam int GPT_B_GATE  = 6;
    localparam int GPT_B_PS_HI = 5;
    localparam int GPT_B_PS_LO = 4;
    localparam int GPT_B_SYNC  = 2;
    localparam int GPT_B_CS    = 1;
    localparam logic [15:0] GPT_CTRL_MASK = 16'hA076;
    // Oscillator control and power-state fields
    localparam int GPT_B_LPOSC = 1;
    localparam int GPT_B_IDLE  = 0;
    localparam int GPT_B_SLEEP = 1;
    // Status bits: period match, gate fall, carry-out wake-up
    localparam int GPT_EV_MATCH = 0;
    localparam int GPT_EV_GATE  = 1;
    localparam int GPT_EV_WAKE  = 2;
    localparam int GPT_NEV      = 3;
    // Reset values
    localparam logic [15:0] GPT_RST_COUNT  = 16'h0000;
    localparam logic [15:0] GPT_RST_PERIOD = 16'hFFFF;
    localparam logic [15:0] GPT_RST_CTRL   = 16'h0000;
    // Prescale terminal counts for 1, 8, 64, 256
    localparam logic [7:0] GPT_PS_DIV1   = 8'h00;
    localparam logic [7:0] GPT_PS_DIV8   = 8'h07;
    localparam logic [7:0] GPT_PS_DIV64  = 8'h3F;
    localparam logic [7:0] GPT_PS_DIV256 = 8'hFF;
    // Instruction cycle is a quarter of the system clock
    localparam int          GPT_ICYC_RATIO = 4;
    localparam logic [1:0]  GPT_ICYC_LAST  = 2'(GPT_ICYC_RATIO - 1);
    // Pin bundle carried together
    typedef struct packed {
        logic ext_clk;  // Gate or external clock pin
        logic lp_osc;   // 32 kHz oscillator output
    } gpt16_pins_t;
    typedef enum logic [2:0] {
        GPT_SRC_ICYC = 3'b001,
        GPT_SRC_SYNC = 3'b010,
        GPT_SRC_ASYN = 3'b100
    } gpt16_src_t;
endpackage
`default_nettype wire

// >>> tb/gpt16_pins_model.sv
// Partner model of the pins: gate or external clock, and the oscillator.
// Assumes the bench clock; the oscillator is a fast stand-in for 32 kHz.
`default_nettype none
module gpt16_pins_model
    import gpt16_pkg::*;
#(
    parameter int OSC_HALF = 6
)
(
    input  wire logic    clk_sys,   // Bench clock
    input  wire logic    ext_run,   // Toggle the external clock when high
    input  wire logic    gate_lvl,  // Pin level while not toggling
    output gpt16_pins_t  pins       // Pins into the timer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div_q = 4'h0;
    logic       ext_q = 1'b0;
    logic       osc_q = 1'b0;
    // External clock of 8 cycles, slow enough for the 2-FF synchroniser
    always @(posedge clk_sys) begin
        div_q <= div_q + 4'h1;
        ext_q <= ext_run ? div_q[2] : gate_lvl;
    end
    // Oscillator runs free; scaled up so that a wrap fits in a short run
    always #(OSC_HALF * 4) osc_q = ~osc_q;
    assign pins = '{ext_clk: ext_q, lp_osc: osc_q};
endmodule
`default_nettype wire

// >>> tb/gpt16_timer_tb.sv
// Self-checking bench of the timer: APB driver, read scoreboard, pin model.
// Assumes the design's APB slave answers in the cycle after setup.
`default_nettype none
module gpt16_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpt16_pkg::*;
    typedef struct {string nm; logic [32:0] exp; int tol;} gpt16_note_t;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, irq, ext_run = 1'b0, gate_lvl = 1'b0;
    gpt16_pins_t pins;
    gpt16_note_t notes[$], nt;
    logic [32:0] seen;
    logic [15:0] rv;
    int n_fail = 0, n_compared = 0;
    int divs[4] = '{1, 8, 64, 256};
    logic [31:0] m_pwr[7] = '{0, 2, 2, 2, 1, 1, 1};
    logic [31:0] m_ctl[7] = '{32'h8006, 32'h8006, 32'h8002, 32'h8000, 32'hA002, 32'hA000, 32'h8000};
    int m_exp[7] = '{50, 0, 50, 0, 0, 0, 100};
    always #2 clk_sys = ~clk_sys;
    gpt16_timer gpt16_timer_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .irq(irq));
    gpt16_pins_model gpt16_pins_model_i (.clk_sys(clk_sys), .ext_run(ext_run),
        .gate_lvl(gate_lvl), .pins(pins));
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            chk("pready", {32'h0000_0000, pready}, 33'h1);
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Note the expected answer, then read; the monitor compares
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input int tol, input string nm);
        notes.push_back('{nm, e, tol});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_irq(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge clk_sys);
            if (irq === 1'b1) return;
        end
        chk("irq wait", {32'h0000_0000, irq}, 33'h1);
        test_done();
    endtask
    // Scoreboard: a count within the noted tolerance counts as a match
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            seen = {pslverr, prdata};
            if (nt.tol != 0 && seen[32] === nt.exp[32] && seen[31:0] <= nt.exp[31:0] + nt.tol
                && seen[31:0] + nt.tol >= nt.exp[31:0]) begin
                seen = nt.exp;
            end
            chk(nt.nm, seen, nt.exp);
        end
    end
    initial begin
        void'($urandom(32'hA1B9_B1C3));
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        // Reset values and an unmapped place
        rd(GPT_OFF_COUNT, 33'h0000, 0, "count");
        rd(GPT_OFF_PERIOD, 33'hFFFF, 0, "period");
        rd(GPT_OFF_STAT, 33'h0000, 0, "status");
        rd(12'h120, {1'b1, 32'h0000_0000}, 0, "unmapped");
        // Control writes must not disturb a written count
        rv = 16'($urandom());
        wr(GPT_OFF_COUNT, {16'h0000, rv});
        repeat (3) wr(GPT_OFF_CTRL, $urandom() & 32'h0000_2076);
        rd(GPT_OFF_COUNT, {17'h0_0000, rv}, 0, "count after control");
        // Every prescale setting; each run starts from a cleared prescaler
        for (int ps = 0; ps < 4; ps++) begin
            wr(GPT_OFF_COUNT, 32'h0000_0000);
            wr(GPT_OFF_CTRL, 32'h0000_8000 | (ps << 4));
            repeat (3072) @(posedge clk_sys);
            wr(GPT_OFF_CTRL, 32'h0000_0000);
            rd(GPT_OFF_COUNT, 33'(768 / divs[ps]), 1, "prescaled count");
        end
        // Period match: flag sticks until cleared, count wraps to zero
        wr(GPT_OFF_IEN, 32'h0000_0001);
        wr(GPT_OFF_PERIOD, 32'h0000_0005);
        wr(GPT_OFF_COUNT, 32'h0000_0000);
        wr(GPT_OFF_CTRL, 32'h0000_8000);
        wait_irq(100);
        wr(GPT_OFF_CTRL, 32'h0000_0000);
        rd(GPT_OFF_COUNT, 33'h0001, 1, "count after wrap");
        rd(GPT_OFF_STAT, 33'h0001, 0, "match flag");
        wr(GPT_OFF_CLR, 32'h0000_0001);
        rd(GPT_OFF_STAT, 33'h0000, 0, "flag cleared");
        chk("irq", {32'h0000_0000, irq}, 33'h0);
        // Modes under Idle and Sleep, external clock toggling throughout
        ext_run <= 1'b1;
        wr(GPT_OFF_PERIOD, 32'h0000_FFFF);
        for (int i = 0; i < 7; i++) begin
            wr(GPT_OFF_PWR, m_pwr[i]);
            wr(GPT_OFF_COUNT, 32'h0000_0000);
            wr(GPT_OFF_CTRL, m_ctl[i]);
            repeat (400) @(posedge clk_sys);
            wr(GPT_OFF_CTRL, 32'h0000_0000);
            rd(GPT_OFF_COUNT, 33'(m_exp[i]), 2, "mode count");
        end
        // Sleep with a short period still matches
        wr(GPT_OFF_PWR, 32'h0000_0002);
        wr(GPT_OFF_PERIOD, 32'h0000_0007);
        wr(GPT_OFF_COUNT, 32'h0000_0000);
        wr(GPT_OFF_CTRL, 32'h0000_8002);
        wait_irq(300);
        wr(GPT_OFF_CTRL, 32'h0000_0000);
        wr(GPT_OFF_CLR, 32'h0000_0007);
        wr(GPT_OFF_PWR, 32'h0000_0000);
        // Gated accumulation: on, internal source, gate bit set
        ext_run <= 1'b0;
        wr(GPT_OFF_IEN, 32'h0000_0002);
        wr(GPT_OFF_PERIOD, 32'h0000_FFFF);
        wr(GPT_OFF_COUNT, 32'h0000_0000);
        wr(GPT_OFF_CTRL, 32'h0000_8040);
        gate_lvl <= 1'b1;
        repeat (200) @(posedge clk_sys);
        gate_lvl <= 1'b0;
        wait_irq(20);
        wr(GPT_OFF_CTRL, 32'h0000_0000);
        rd(GPT_OFF_COUNT, 33'd50, 2, "gated count");
        rd(GPT_OFF_STAT, 33'h0002, 0, "gate fall flag");
        wr(GPT_OFF_CLR, 32'h0000_0002);
        // Low-power oscillator: asynchronous counting, wake on carry-out
        wr(GPT_OFF_IEN, 32'h0000_0004);
        wr(GPT_OFF_OSC, 32'h0000_0002);
        wr(GPT_OFF_PWR, 32'h0000_0002);
        wr(GPT_OFF_COUNT, 32'h0000_FFF0);
        wr(GPT_OFF_CTRL, 32'h0000_8002);
        wait_irq(3000);
        rd(GPT_OFF_STAT, 33'h0005, 0, "wake and match flags");
        test_done();
    end
endmodule
`default_nettype wire
